// ---- verilog/sba_arbiter.sv ----
/*
  system bus arbiter: ownership, snoop control, memory arbitration, refresh.
  assumes the owner issues one cyc_valid_i strobe and waits for cyc_ack_o;
  write queue, read queues and bus bridges sit outside and follow the strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module sba_arbiter
  import sba_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cpu_req_i,
  input  wire logic [NUM_VL-1:0] vl_req_i,
  input  wire logic              dma_hold_request_i,
  input  wire logic              cyc_valid_i,
  input  wire sba_tgt_t          cyc_tgt_i,
  input  wire logic              cyc_wr_i,
  input  wire logic [ADDR_W-1:0] cyc_addr_i,
  input  wire logic              capture_cfg_i,
  input  wire logic              wq_full_i,
  input  wire logic              wq_nempty_i,
  input  wire logic [ADDR_W-1:0] wq_addr_i,
  input  wire logic              snoop_done_i,
  input  wire logic              snoop_dirty_i,
  input  wire logic              xover_done_i,
  output logic                   cpu_gnt_o,
  output logic [NUM_VL-1:0]      vl_gnt_o,
  output logic                   dma_hold_grant_o,
  output logic                   cyc_ack_o,
  output logic                   wq_push_o,
  output logic                   wq_pop_o,
  output logic                   snoop_cyc_o,
  output logic [ADDR_W-1:0]      snoop_addr_o,
  output logic                   snoop_capture_o,
  output logic                   xover_o,
  output logic                   xover_isa_o,
  output logic [2:0]             rq_fill_o,
  output logic                   isa_refresh_o,
  output logic                   ras_n_o,
  output logic                   cas_n_o,
  output logic                   we_n_o,
  output logic [MA_W-1:0]        ma_o
);
  typedef struct packed {
    logic [2:0]        sync;
    logic              hold_f;
    sba_own_t          own;
    logic [1:0]        vl_idx;
    sba_st_t           st;
    sba_tgt_t          tgt;
    logic [ADDR_W-1:0] addr;
    logic              pf_on;
    logic              pf_drop;
    logic [1:0]        pf_cnt;
    logic [ADDR_W-1:0] pf_head;
    logic [ADDR_W-1:0] pf_next;
    logic              rd_pend;
    sba_dst_t          rd_dst;
    logic              mem_busy;
    logic              mem_pf;
    sba_mk_t           mem_kind;
    sba_dst_t          mem_dst;
    logic [REF_W-1:0]  ref_cnt;
    logic              ref_due;
    logic [REF_W-1:0]  isa_cnt;
    logic              isa_ref;
    logic              ack;
    logic              push;
    logic              snoop;
    logic              capture;
    logic              xover;
    logic [2:0]        fill;
  } sba_arb_t;

  sba_arb_t          arb_ff;
  sba_arb_t          nxt_arb;
  logic              own_req;
  logic              mem_start;
  sba_mk_t           mem_kind;
  logic [ADDR_W-1:0] mem_addr;
  logic              seq_busy;
  logic              seq_done;

  // owner still requesting
  always_comb begin
    case (arb_ff.own)
      OWN_CPU: own_req = cpu_req_i;
      OWN_VL:  own_req = vl_req_i[arb_ff.vl_idx];
      OWN_DMA: own_req = arb_ff.hold_f;
      default: own_req = 1'b0;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_arb         = arb_ff;
    nxt_arb.ack     = 1'b0;
    nxt_arb.push    = 1'b0;
    nxt_arb.snoop   = 1'b0;
    nxt_arb.capture = 1'b0;
    nxt_arb.isa_ref = 1'b0;
    nxt_arb.fill    = 3'h0;
    mem_start       = 1'b0;
    mem_kind        = MK_READ;
    mem_addr        = arb_ff.addr;
    // hold request from pin: three flops, second and third must agree
    nxt_arb.sync = {arb_ff.sync[1:0], dma_hold_request_i};
    if (arb_ff.sync[1] == arb_ff.sync[2]) begin
      nxt_arb.hold_f = arb_ff.sync[2];
    end
    if (arb_ff.isa_cnt == '0) begin
      nxt_arb.isa_cnt = ISA_REF_LAST;
      nxt_arb.isa_ref = 1'b1;
    end else begin
      nxt_arb.isa_cnt = arb_ff.isa_cnt - 1'b1;
    end
    if (arb_ff.ref_cnt == '0) begin
      nxt_arb.ref_cnt = DRAM_REF_LAST;
      nxt_arb.ref_due = 1'b1;
    end else begin
      nxt_arb.ref_cnt = arb_ff.ref_cnt - 1'b1;
    end
    case (arb_ff.st)
      // fixed priority: dma controller, local masters, processor
      ST_IDLE: begin
        if (arb_ff.hold_f) begin
          nxt_arb.own = OWN_DMA;
          nxt_arb.st  = ST_OWNED;
        end else if (vl_req_i != '0) begin
          nxt_arb.own = OWN_VL;
          nxt_arb.st  = ST_OWNED;
          for (int i = NUM_VL - 1; i >= 0; i--) begin
            if (vl_req_i[i]) begin
              nxt_arb.vl_idx = 2'(i);
            end
          end
        end else if (cpu_req_i) begin
          nxt_arb.own = OWN_CPU;
          nxt_arb.st  = ST_OWNED;
        end
      end
      // grant held until owner drops its request
      ST_OWNED: begin
        if (!own_req) begin
          nxt_arb.own = OWN_NONE;
          nxt_arb.st  = ST_IDLE;
        end else if (cyc_valid_i) begin
          nxt_arb.tgt  = cyc_tgt_i;
          nxt_arb.addr = cyc_addr_i;
          if (cyc_tgt_i != TGT_MEM) begin
            // crossover, also dma onto the local bus
            nxt_arb.xover = 1'b1;
            nxt_arb.st    = ST_XOVER;
          end else if (cyc_wr_i) begin
            // post write, stall while queue full
            if (!wq_full_i) begin
              nxt_arb.push = 1'b1;
              nxt_arb.ack  = 1'b1;
            end
          end else if (arb_ff.own == OWN_CPU) begin
            if (arb_ff.pf_cnt != 2'h0 && cyc_addr_i == arb_ff.pf_head) begin
              nxt_arb.pf_cnt  = arb_ff.pf_cnt - 2'h1;
              nxt_arb.pf_head = arb_ff.pf_head + 1'b1;
              nxt_arb.ack     = 1'b1;
            end else begin
              nxt_arb.pf_on   = 1'b1;
              nxt_arb.pf_cnt  = 2'h0;
              nxt_arb.pf_drop = arb_ff.mem_busy && arb_ff.mem_pf;
              nxt_arb.pf_head = cyc_addr_i + 1'b1;
              nxt_arb.pf_next = cyc_addr_i + 1'b1;
              nxt_arb.rd_pend = 1'b1;
              nxt_arb.rd_dst  = DST_CPU;
              nxt_arb.st      = ST_MEMRD;
            end
          end else begin
            // snoop on the processor bus, processor is not owner
            nxt_arb.snoop = 1'b1;
            nxt_arb.st    = ST_SNOOP;
          end
        end
      end
      ST_SNOOP: begin
        if (snoop_done_i) begin
          if (snoop_dirty_i && capture_cfg_i) begin
            // take the write-back data on the fly
            nxt_arb.capture = 1'b1;
            nxt_arb.ack     = 1'b1;
            nxt_arb.st      = ST_OWNED;
          end else begin
            nxt_arb.rd_pend = 1'b1;
            nxt_arb.rd_dst  = (arb_ff.own == OWN_DMA) ? DST_ISA : DST_VL;
            nxt_arb.st      = ST_MEMRD;
          end
        end
      end
      ST_XOVER: begin
        if (xover_done_i) begin
          nxt_arb.xover = 1'b0;
          nxt_arb.ack   = 1'b1;
          nxt_arb.st    = ST_OWNED;
        end
      end
      default: begin
      end
    endcase
    // memory arbitration: refresh, write drain, demand read, prefetch
    if (!arb_ff.mem_busy && !seq_busy) begin
      if (arb_ff.ref_due) begin
        mem_start       = 1'b1;
        mem_kind        = MK_REFRESH;
        nxt_arb.ref_due = (arb_ff.ref_cnt == '0);
      end else if (wq_nempty_i) begin
        mem_start = 1'b1;
        mem_kind  = MK_WRITE;
        mem_addr  = wq_addr_i;
      end else if (arb_ff.rd_pend) begin
        mem_start       = 1'b1;
        nxt_arb.rd_pend = 1'b0;
        nxt_arb.mem_dst = arb_ff.rd_dst;
      end else if (arb_ff.pf_on && arb_ff.pf_cnt != PF_FULL && nxt_arb.st != ST_MEMRD) begin
        mem_start       = 1'b1;
        mem_addr        = arb_ff.pf_next;
        nxt_arb.pf_next = arb_ff.pf_next + 1'b1;
        nxt_arb.mem_dst = DST_CPU;
      end
      nxt_arb.mem_busy = mem_start;
      nxt_arb.mem_kind = mem_kind;
      nxt_arb.mem_pf   = mem_start && !arb_ff.ref_due && !wq_nempty_i && !arb_ff.rd_pend;
    end
    // read completion fills the queue of the requesting bus
    if (seq_done) begin
      nxt_arb.mem_busy = 1'b0;
      // a miss in this very cycle also makes the finishing prefetch stale
      if (arb_ff.mem_kind == MK_READ && !(arb_ff.mem_pf && nxt_arb.pf_drop)) begin
        nxt_arb.fill[arb_ff.mem_dst] = 1'b1;
        if (arb_ff.mem_pf) begin
          nxt_arb.pf_cnt = nxt_arb.pf_cnt + 2'h1;
        end else begin
          nxt_arb.ack = 1'b1;
          nxt_arb.st  = ST_OWNED;
        end
      end
      if (arb_ff.mem_pf) begin
        nxt_arb.pf_drop = 1'b0;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      arb_ff <= '0;
    end else begin
      arb_ff <= nxt_arb;
    end
  end

  // dram strobe sequencer
  sba_dram_seq u_dram (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (mem_start),
    .kind_i  (mem_kind),
    .addr_i  (mem_addr),
    .busy_o  (seq_busy),
    .done_o  (seq_done),
    .ras_n_o (ras_n_o),
    .cas_n_o (cas_n_o),
    .we_n_o  (we_n_o),
    .ma_o    (ma_o)
  );

  // grants decoded from the single owner register
  for (genvar g = 0; g < NUM_VL; g++) begin : g_vl_gnt
    assign vl_gnt_o[g] = (arb_ff.own == OWN_VL) && (arb_ff.vl_idx == 2'(g));
  end
  assign cpu_gnt_o        = (arb_ff.own == OWN_CPU);
  // hold grant while dma owns the buses
  assign dma_hold_grant_o = (arb_ff.own == OWN_DMA);
  assign cyc_ack_o        = arb_ff.ack;
  assign wq_push_o        = arb_ff.push;
  assign wq_pop_o         = seq_done && (arb_ff.mem_kind == MK_WRITE);
  assign snoop_cyc_o      = arb_ff.snoop;
  assign snoop_addr_o     = arb_ff.addr;
  assign snoop_capture_o  = arb_ff.capture;
  assign xover_o          = arb_ff.xover;
  assign xover_isa_o      = (arb_ff.tgt == TGT_ISA);
  assign rq_fill_o        = arb_ff.fill;
  assign isa_refresh_o    = arb_ff.isa_ref;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic owned_cyc;
  assign owned_cyc = (arb_ff.st == ST_OWNED) && own_req && cyc_valid_i;

  property p_one_owner;
    $onehot0({cpu_gnt_o, vl_gnt_o, dma_hold_grant_o});
  endproperty
  a_one_owner: assert property (p_one_owner) else $error("more than one grant");
  property p_hold_grant;
    $rose(dma_hold_grant_o) |-> $past(arb_ff.hold_f) && !cpu_gnt_o;
  endproperty
  a_hold_grant: assert property (p_hold_grant) else $error("hold grant without request");
  property p_snoop;
    owned_cyc && arb_ff.own != OWN_CPU && cyc_tgt_i == TGT_MEM && !cyc_wr_i |=> snoop_cyc_o ##1 !snoop_cyc_o;
  endproperty
  a_snoop: assert property (p_snoop) else $error("memory read without snoop");
  property p_capture;
    snoop_capture_o |-> $past(snoop_done_i && snoop_dirty_i && capture_cfg_i) && cyc_ack_o;
  endproperty
  a_capture: assert property (p_capture) else $error("capture without dirty hit");
  property p_post;
    owned_cyc && cyc_tgt_i == TGT_MEM && cyc_wr_i && !wq_full_i |=> wq_push_o && cyc_ack_o;
  endproperty
  a_post: assert property (p_post) else $error("write not posted");
  property p_full_stall;
    owned_cyc && cyc_wr_i && wq_full_i |=> !wq_push_o;
  endproperty
  a_full_stall: assert property (p_full_stall) else $error("push into full queue");
  property p_pf_depth;
    arb_ff.pf_cnt <= PF_FULL;
  endproperty
  a_pf_depth: assert property (p_pf_depth) else $error("prefetch depth exceeded");
  property p_refresh;
    $rose(arb_ff.ref_due) |-> ##[0:40] (mem_start && mem_kind == MK_REFRESH);
  endproperty
  a_refresh: assert property (p_refresh) else $error("dram refresh starved");
  property p_isa_ref;
    isa_refresh_o |=> !isa_refresh_o [*8];
  endproperty
  a_isa_ref: assert property (p_isa_ref) else $error("isa refresh too frequent");
  property p_xover;
    owned_cyc && cyc_tgt_i != TGT_MEM |=> xover_o && xover_isa_o == (cyc_tgt_i == TGT_ISA);
  endproperty
  a_xover: assert property (p_xover) else $error("crossover not started");
  c_capture: cover property (snoop_cyc_o ##[1:20] snoop_capture_o);
  c_pf_hit: cover property (cpu_gnt_o && arb_ff.pf_cnt == PF_FULL ##[1:30] cyc_ack_o);
  c_dma: cover property ($rose(dma_hold_grant_o) ##[1:50] rq_fill_o[DST_ISA]);
endmodule // sba_arbiter
`default_nettype wire

// ---- verilog/sba_pkg.sv ----
/*
  shared constants and types of the system bus arbiter with snoop control.
  assumes a single 100 MHz clock for every consumer of this package.
*/
package sba_pkg;
  // ----------------------------------------
  // bus widths and population
  // ----------------------------------------
  localparam int CLK_MHZ      = 100;
  localparam int CPU_BUS_W    = 64;
  localparam int VL_BUS_W     = 32;
  localparam int ISA_BUS_W    = 16;
  localparam int NUM_VL       = 3;
  localparam int NUM_DMA      = 7;
  localparam int NUM_ISA_MST  = 6;
  localparam int ADDR_W       = 22;   // qword address
  localparam int MA_W         = 11;
  localparam int PF_BLOCKS    = 2;
  localparam int PF_BLK_BYTES = 8;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int DRAM_REF_NS  = 15600;
  localparam int ISA_REF_NS   = 15000;
  localparam int T_RCD_NS     = 20;
  localparam int T_CAS_NS     = 30;
  localparam int T_RP_NS      = 30;
  localparam int DRAM_REF_CYC = DRAM_REF_NS * CLK_MHZ / 1000;
  localparam int ISA_REF_CYC  = ISA_REF_NS * CLK_MHZ / 1000;
  localparam int T_RCD_CYC    = (T_RCD_NS * CLK_MHZ + 999) / 1000;
  localparam int T_CAS_CYC    = (T_CAS_NS * CLK_MHZ + 999) / 1000;
  localparam int T_RP_CYC     = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int REF_W        = 12;
  localparam logic [REF_W-1:0] DRAM_REF_LAST = REF_W'(DRAM_REF_CYC - 1);
  localparam logic [REF_W-1:0] ISA_REF_LAST  = REF_W'(ISA_REF_CYC - 1);
  localparam logic [3:0]       CNT_RCD       = 4'(T_RCD_CYC - 1);
  localparam logic [3:0]       CNT_CAS       = 4'(T_CAS_CYC - 1);
  localparam logic [3:0]       CNT_RP        = 4'(T_RP_CYC - 1);
  localparam logic [3:0]       CNT_REF       = 4'(T_RCD_CYC + T_CAS_CYC - 1);
  localparam logic [1:0]       PF_FULL       = 2'(PF_BLOCKS);
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {TGT_MEM, TGT_VL, TGT_ISA} sba_tgt_t;
  typedef enum logic [2:0] {OWN_NONE, OWN_CPU, OWN_VL, OWN_DMA} sba_own_t;
  typedef enum logic [2:0] {ST_IDLE, ST_OWNED, ST_SNOOP, ST_MEMRD, ST_XOVER} sba_st_t;
  typedef enum logic [1:0] {MK_READ, MK_WRITE, MK_REFRESH} sba_mk_t;
  typedef enum logic [1:0] {DST_CPU, DST_VL, DST_ISA} sba_dst_t;
  typedef enum logic [1:0] {DS_IDLE, DS_ROW, DS_COL, DS_PRE} sba_ds_t;
endpackage

// ---- verilog/sba_dram_seq.sv ----
/*
  dram strobe sequencer: one read, write or ras-only refresh per start.
  assumes start_i only while busy_o is low; address is row over column.
*/
`timescale 1ns/1ps
`default_nettype none
module sba_dram_seq
  import sba_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              start_i,
  input  wire sba_mk_t           kind_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  output logic                   busy_o,
  output logic                   done_o,
  output logic                   ras_n_o,
  output logic                   cas_n_o,
  output logic                   we_n_o,
  output logic [MA_W-1:0]        ma_o
);
  typedef struct packed {
    sba_ds_t           st;
    logic [3:0]        cnt;
    sba_mk_t           kind;
    logic [ADDR_W-1:0] addr;
    logic [MA_W-1:0]   ref_row;
    logic              done;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [MA_W-1:0]   ma;
  } sba_seq_t;

  localparam sba_seq_t SEQ_RST = '{st: DS_IDLE, cnt: 4'h0, kind: MK_READ, addr: '0, ref_row: '0,
                                   done: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ma: '0};
  sba_seq_t seq_ff;
  sba_seq_t nxt_seq;

  // ----------------------------------------
  // row, column, precharge sequence
  // ----------------------------------------
  always_comb begin
    nxt_seq      = seq_ff;
    nxt_seq.done = 1'b0;
    case (seq_ff.st)
      DS_IDLE: begin
        if (start_i) begin
          nxt_seq.st    = DS_ROW;
          nxt_seq.kind  = kind_i;
          nxt_seq.addr  = addr_i;
          nxt_seq.ras_n = 1'b0;
          nxt_seq.ma    = (kind_i == MK_REFRESH) ? seq_ff.ref_row : addr_i[ADDR_W-1 -: MA_W];
          nxt_seq.cnt   = (kind_i == MK_REFRESH) ? CNT_REF : CNT_RCD;
        end
      end
      DS_ROW: begin
        if (seq_ff.cnt != 4'h0) begin
          nxt_seq.cnt = seq_ff.cnt - 4'h1;
        end else if (seq_ff.kind == MK_REFRESH) begin
          nxt_seq.st      = DS_PRE;
          nxt_seq.ras_n   = 1'b1;
          nxt_seq.cnt     = CNT_RP;
          nxt_seq.ref_row = seq_ff.ref_row + 1'b1;
        end else begin
          nxt_seq.st    = DS_COL;
          nxt_seq.ma    = seq_ff.addr[MA_W-1:0];
          nxt_seq.cas_n = 1'b0;
          nxt_seq.we_n  = (seq_ff.kind != MK_WRITE);
          nxt_seq.cnt   = CNT_CAS;
        end
      end
      DS_COL: begin
        if (seq_ff.cnt != 4'h0) begin
          nxt_seq.cnt = seq_ff.cnt - 4'h1;
        end else begin
          nxt_seq.st    = DS_PRE;
          nxt_seq.ras_n = 1'b1;
          nxt_seq.cas_n = 1'b1;
          nxt_seq.we_n  = 1'b1;
          nxt_seq.cnt   = CNT_RP;
        end
      end
      default: begin
        if (seq_ff.cnt != 4'h0) begin
          nxt_seq.cnt = seq_ff.cnt - 4'h1;
        end else begin
          nxt_seq.st   = DS_IDLE;
          nxt_seq.done = 1'b1;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      seq_ff <= SEQ_RST;
    end else begin
      seq_ff <= nxt_seq;
    end
  end

  assign busy_o  = (seq_ff.st != DS_IDLE);
  assign done_o  = seq_ff.done;
  assign ras_n_o = seq_ff.ras_n;
  assign cas_n_o = seq_ff.cas_n;
  assign we_n_o  = seq_ff.we_n;
  assign ma_o    = seq_ff.ma;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_cas_in_row;
    @(posedge clk_i) disable iff (rst_i) !cas_n_o |-> !ras_n_o;
  endproperty
  a_cas_in_row: assert property (p_cas_in_row) else $error("column strobe outside row strobe");
endmodule // sba_dram_seq
`default_nettype wire

// ---- test/sba_partner.sv ----
/*
  far-side model: write queue, processor snoop responder, crossover bridge.
  assumes single-cycle push, pop and snoop strobes from the arbiter on clk_i; xover_i is held until done.
*/
`timescale 1ns/1ps
`default_nettype none
module sba_partner
  import sba_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              dirty_i,
  input  wire logic              wq_push_i,
  input  wire logic              wq_pop_i,
  input  wire logic              snoop_cyc_i,
  input  wire logic              xover_i,
  input  wire logic [ADDR_W-1:0] push_addr_i,
  output logic                   wq_full_o,
  output logic                   wq_nempty_o,
  output logic [ADDR_W-1:0]      wq_addr_o,
  output logic                   snoop_done_o,
  output logic                   snoop_dirty_o,
  output logic                   xover_done_o
);
  logic [3:0] cnt_ff;
  logic [1:0] sh_ff;
  logic [2:0] xc_ff;
  // ----------------------------------------
  // queue level, eight qwords deep
  // ----------------------------------------
  assign wq_full_o   = (cnt_ff == 4'h8);
  assign wq_nempty_o = (cnt_ff != 4'h0);
  // only the processor holds dirty lines
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
      sh_ff <= '0;
      xc_ff <= '0;
      wq_addr_o <= '0;
      snoop_done_o <= 1'b0;
      snoop_dirty_o <= 1'b0;
      xover_done_o <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 4'(wq_push_i) - 4'(wq_pop_i);
      if (wq_push_i) begin
        wq_addr_o <= push_addr_i; // latched cycle address stands during the push
      end
      sh_ff <= {sh_ff[0], snoop_cyc_i};
      snoop_done_o <= sh_ff[1];
      snoop_dirty_o <= sh_ff[1] ? dirty_i : ~snoop_dirty_o; // toggles when not valid
      xc_ff <= xover_i ? xc_ff + 3'h1 : 3'h0;
      xover_done_o <= xover_i && (xc_ff == 3'h2);
    end
  end
endmodule // sba_partner
`default_nettype wire

// ---- test/tb_system_bus_arbiter_snoop.sv ----
/*
  self-checking bench for the system bus arbiter.
  assumes the far-side model in sba_partner and a 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_system_bus_arbiter_snoop;
  import sba_pkg::*;
  logic clk_i, rst_i, cpu_req_i, dma_hold_request_i, cyc_valid_i, cyc_wr_i, capture_cfg_i, dirty_i;
  logic wq_full_i, wq_nempty_i, snoop_done_i, snoop_dirty_i, xover_done_i;
  logic cpu_gnt_o, dma_hold_grant_o, cyc_ack_o, wq_push_o, wq_pop_o, snoop_cyc_o, snoop_capture_o;
  logic xover_o, xover_isa_o, isa_refresh_o, ras_n_o, cas_n_o, we_n_o;
  logic [NUM_VL-1:0] vl_req_i, vl_gnt_o;
  logic [ADDR_W-1:0] cyc_addr_i, wq_addr_i, snoop_addr_o;
  logic [2:0]        rq_fill_o;
  logic [MA_W-1:0]   ma_o;
  logic [10:0]       seen;
  logic [MA_W-1:0]   col_ma;
  sba_tgt_t          cyc_tgt_i;
  int                bad_count, n_checks;
  sba_arbiter dut (.*);
  sba_partner prt (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .dirty_i       (dirty_i),
    .wq_push_i     (wq_push_o),
    .wq_pop_i      (wq_pop_o),
    .snoop_cyc_i   (snoop_cyc_o),
    .xover_i       (xover_o),
    .push_addr_i   (snoop_addr_o),
    .wq_full_o     (wq_full_i),
    .wq_nempty_o   (wq_nempty_i),
    .wq_addr_o     (wq_addr_i),
    .snoop_done_o  (snoop_done_i),
    .snoop_dirty_o (snoop_dirty_i),
    .xover_done_o  (xover_done_i)
  );
  // ----------------------------------------
  // clock and shared tasks
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic tick(int n);
    repeat (n) begin
      @(posedge clk_i);
      #1;
    end
  endtask
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // wait for a grant pattern {hold, local, cpu}
  task automatic gw(logic [4:0] exp, int lim);
    for (int k = 0; k < lim && {dma_hold_grant_o, vl_gnt_o, cpu_gnt_o} !== exp; k++) tick(1);
    chk("grants", {dma_hold_grant_o, vl_gnt_o, cpu_gnt_o}, exp);
    if ({dma_hold_grant_o, vl_gnt_o, cpu_gnt_o} !== exp) conclude();
  endtask
  // idle edge first, then one cycle strobe, held target until ack; collects side pulses
  task automatic cyc(sba_tgt_t t, logic wr, logic [ADDR_W-1:0] a, int lim);
    int k;
    tick(1);
    cyc_tgt_i = t;
    cyc_wr_i = wr;
    cyc_addr_i = a;
    cyc_valid_i = 1'b1;
    seen = '0;
    for (k = 0; k < lim; k++) begin
      tick(1);
      cyc_valid_i = 1'b0;
      seen |= {wq_pop_o, ~we_n_o, wq_push_o, snoop_capture_o, snoop_cyc_o, xover_o, xover_isa_o, ~ras_n_o, rq_fill_o};
      if (cas_n_o === 1'b0) col_ma = ma_o;
      if (cyc_ack_o === 1'b1) break;
    end
    if (k == lim) begin
      bad_count++;
      conclude();
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_vl;
    cpu_req_i = 1'b1;
    vl_req_i = 3'b110;
    gw(5'b00100, 4);
    cyc(TGT_MEM, 1'b1, 22'h000123, 6);
    chk("wr", seen[8:6], 3'b100);
    capture_cfg_i = 1'b1;
    dirty_i = 1'b1;
    cyc(TGT_MEM, 1'b0, 22'h000200, 60);
    chk("cap", seen[8:6], 3'b011);
    chk("saddr", snoop_addr_o, 22'h000200);
    capture_cfg_i = 1'b0;
    dirty_i = 1'b0;
    cyc(TGT_MEM, 1'b0, 22'h000240, 300);
    chk("rd", {seen[7:6], seen[3:0]}, 6'b011010);
    chk("drain", seen[10:9], 2'b11);
    vl_req_i = 3'b100;
    gw(5'b00000, 3);
    gw(5'b01000, 3);
    vl_req_i = 3'b000;
    gw(5'b00001, 4);
  endtask
  task automatic s_cpu;
    cyc(TGT_ISA, 1'b0, 22'h000010, 20);
    chk("xisa", seen[6:4], 3'b011);
    cyc(TGT_VL, 1'b1, 22'h000020, 20);
    chk("xvl", seen[6:4], 3'b010);
    cyc(TGT_MEM, 1'b0, 22'h001005, 300);
    chk("cpurd", {seen[6], seen[3:0]}, 5'b01001);
    chk("col", col_ma, 11'h005);
    tick(25);
    cyc(TGT_MEM, 1'b0, 22'h001006, 4);
    chk("pfhit", {seen[6], seen[3:0]}, 5'b00000);
  endtask
  task automatic s_hold;
    int k;
    dma_hold_request_i = 1'b1;
    tick(30);
    chk("busy", {dma_hold_grant_o, cpu_gnt_o}, 2'b01);
    cpu_req_i = 1'b0;
    gw(5'b10000, 6);
    cyc(TGT_MEM, 1'b0, 22'h000300, 300);
    chk("dmard", {seen[6], seen[2:0]}, 4'b1100);
    cyc(TGT_VL, 1'b1, 22'h000040, 20);
    chk("dmavl", seen[5:4], 2'b10);
    for (k = 0; k < 1600 && isa_refresh_o !== 1'b1; k++) tick(1);
    tick(1);
    for (k = 1; k < 1600 && isa_refresh_o !== 1'b1; k++) tick(1);
    chk("isaref", k, ISA_REF_CYC);
    if (k == 1600) conclude();
    dma_hold_request_i = 1'b0;
    gw(5'b00000, 6);
  endtask
  initial begin
    rst_i = 1'b1;
    cpu_req_i = 1'b0;
    vl_req_i = '0;
    dma_hold_request_i = 1'b0;
    cyc_valid_i = 1'b0;
    cyc_tgt_i = TGT_MEM;
    cyc_wr_i = 1'b0;
    cyc_addr_i = '0;
    capture_cfg_i = 1'b0;
    dirty_i = 1'b0;
    tick(12);
    chk("rst", {cpu_gnt_o, vl_gnt_o, dma_hold_grant_o, ras_n_o, cas_n_o, we_n_o}, 8'h07);
    rst_i = 1'b0;
    s_vl();
    s_cpu();
    s_hold();
    conclude();
  end
endmodule // tb_system_bus_arbiter_snoop
`default_nettype wire
